/* File: flash_ctl_cfg.svh */
/*
 * Offsets, field positions, reset values and operation codes of the flash
 * program/erase controller. Assumes inclusion by its bare name.
 */
`ifndef FLASH_CTL_CFG_SVH
`define FLASH_CTL_CFG_SVH
`define OFF_CONTROL 8'h00
`define OFF_CONTROL_SECOND 8'h10
`define POS_LAUNCH 15
`define POS_PERMIT 14
`define POS_FAIL 13
`define POS_LOWV 12
`define POS_HOT 8
`define POS_RETRY_TAG 28
`define POS_SLEEP 24
`define POS_WAIT 16
`define POS_TEMP 14
`define POS_CREAD 13
`define POS_VREAD 12
`define POS_STRENGTH 8
`define RST_SLEEP 1'h1
`define RST_WAIT 5'h1f
`define OP_NONE 4'h0
`define OP_WORD 4'h1
`define OP_QUAD 4'h2
`define OP_ROW 4'h3
`define OP_PAGE 4'h4
`define OP_LOWER 4'h5
`define OP_UPPER 4'h6
`define OP_ALL 4'h7
`define ECC_ALWAYS 2'h0
`define CREAD_ONES 32'h0001_0000
`define CREAD_LOW_ONES 32'h0000_0001
`endif

/* File: flash_ctl_pkg.sv */
/*
 * Types for the flash program/erase controller.
 * Assumes flash_ctl_cfg.svh is compiled alongside.
 */
package flash_ctl_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	typedef struct packed {
		logic start;
		logic [3:0] op;
		logic [1:0] strength;
		logic verify;
	} flash_cmd_type;
	typedef struct packed {
		logic done;
		logic fail;
		logic low_supply;
		logic hot;
	} flash_stat_type;
	typedef enum logic [1:0] {
		st_idle,
		st_check,
		st_run,
		st_finish
	} seq_state_type;
endpackage : flash_ctl_pkg

/* File: flash_program_erase_control.sv */
/*
 * Program/erase sequencer with its two control registers.
 * Assumes: the flash array answers a start pulse with a done pulse, key logic
 * gives unlock_ok, protection logic gives target_protected / region_protected.
 */
// Summary of operation
// - Launch bit starts the selected operation; hardware clears it on completion.
// - Launch bit changes only with permit, temperature grade one, and unlock.
// - Permit bit is read/write; zero blocks launch writes.
// - Fail flag sets when an operation fails; stays zero on success.
// - Low-supply flag captured only during launched operations.
// - Hot flag captured only during launched operations.
// - Launch with no-operation code clears all three flags.
// - Main control fields reset only by power-on reset.
// - Operation select writable only while permit is zero.
// - Codes 0 to 3: nothing, word, 256-bit word, row program.
// - Codes 4 to 7: page, lower, upper, full erase; rest reserved.
// - Protected targets or regions are never programmed or erased.
// - Word program is refused and sets the fail flag when ECC setting is 00.
// - Retry progress tag is plain storage, reset zero.
// - Sleep power bit resets one and changes only after unlock.
// - Wait count resets all ones and changes only after unlock.
// - Temperature grade picks read latency; reset value from configuration.
// - Temperature grade zero blocks every launch.
// - Temperature grade changes only when idle and unlocked.
// - Compare read returns ones-pattern words or all zero words.
// - Compare read acts only in verify mode; changes after unlock.
// - Verify mode picks retry-with-verify or single erase.
// - Strength step field used in verify mode; changes only while idle.
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
module flash_program_erase_control #(
	parameter int WORDS = 8
) (
	clk,
	rst,
	por,
	temp_cfg,
	req,
	rdata,
	unlock_ok,
	target_protected,
	region_protected,
	ecc_setting,
	low_supply_det,
	hot_det,
	stat,
	cmd,
	flash_word,
	cread_word_valid,
	cread_word,
	read_word,
	power_down_in_sleep,
	wait_count,
	low_latency_reads
);
	import flash_ctl_pkg::*;
	input wire logic clk;
	input wire logic rst;
	input wire logic por;
	input wire logic temp_cfg;
	input wire flash_ctl_pkg::reg_req_type req;
	output logic [31:0] rdata;
	input wire logic unlock_ok;
	input wire logic target_protected;
	input wire logic region_protected;
	input wire logic [1:0] ecc_setting;
	input wire logic low_supply_det;
	input wire logic hot_det;
	input wire flash_ctl_pkg::flash_stat_type stat;
	output flash_ctl_pkg::flash_cmd_type cmd;
	input wire logic [32*WORDS-1:0] flash_word;
	input wire logic cread_word_valid;
	input wire logic [$clog2(WORDS)-1:0] cread_word;
	output logic [31:0] read_word;
	output logic power_down_in_sleep;
	output logic [4:0] wait_count;
	output logic low_latency_reads;

	////////////////////////////////////////////////////////////////////////////
	logic launch_ff, permit_ff, fail_ff, lowv_ff, hot_ff;
	logic [3:0] op_ff;
	logic [3:0] tag_ff;
	logic sleep_ff, temp_ff, cread_ff, vread_ff, temp_loaded_ff;
	logic [4:0] wait_ff;
	logic [1:0] strength_ff;
	seq_state_type state_ff, nxt_state;
	logic wr_ctl, wr_ctl2, launch_req, cleared_by_nop, runs;

	function automatic logic op_allowed(input logic [3:0] op, input logic tp, input logic rp,
		input logic [1:0] ecc);
		logic ok;
		ok = 1'b0;
		unique case (op)
			`OP_WORD: ok = !tp && (ecc != `ECC_ALWAYS);
			`OP_QUAD, `OP_ROW, `OP_PAGE: ok = !tp;
			`OP_LOWER, `OP_UPPER, `OP_ALL: ok = !rp;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : op_allowed

	assign wr_ctl = req.wr && (req.addr == `OFF_CONTROL);
	assign wr_ctl2 = req.wr && (req.addr == `OFF_CONTROL_SECOND);
	// Gate on the launch bit itself so a busy launch cannot be re-armed.
	assign launch_req = wr_ctl && req.wdata[`POS_LAUNCH] && !launch_ff && permit_ff
		&& temp_ff && unlock_ok;
	assign cleared_by_nop = launch_req && (op_ff == `OP_NONE);
	assign runs = (state_ff == st_run);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_idle: if (launch_req) nxt_state = st_check;
			st_check: nxt_state = (op_ff != `OP_NONE)
				&& op_allowed(op_ff, target_protected, region_protected, ecc_setting)
				? st_run : st_finish;
			st_run: if (stat.done) nxt_state = st_finish;
			st_finish: nxt_state = st_idle;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst || por) begin
			state_ff <= st_idle;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || por) begin
			cmd <= '0;
		end else begin
			cmd.start <= (state_ff == st_check) && (nxt_state == st_run);
			cmd.op <= op_ff;
			cmd.strength <= strength_ff;
			cmd.verify <= vread_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main control: power-on reset only, the system reset leaves it alone.
	always_ff @(posedge clk) begin
		if (por) begin
			launch_ff <= 1'b0;
		end else if (launch_req) begin
			launch_ff <= 1'b1;
		end else if (state_ff == st_finish || state_ff == st_idle) begin
			// A system reset that aborts the sequencer must not leave launch stuck high.
			launch_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (por) begin
			permit_ff <= 1'b0;
			op_ff <= `OP_NONE;
		end else if (wr_ctl) begin
			permit_ff <= req.wdata[`POS_PERMIT];
			if (!permit_ff) op_ff <= req.wdata[3:0];
		end
	end

	// A hardware set wins over the no-op clear in the same cycle.
	always_ff @(posedge clk) begin
		if (por) begin
			fail_ff <= 1'b0;
			lowv_ff <= 1'b0;
			hot_ff <= 1'b0;
		end else begin
			if (runs && stat.done && stat.fail) fail_ff <= 1'b1;
			else if (state_ff == st_check && nxt_state == st_finish && op_ff != `OP_NONE)
				fail_ff <= 1'b1;
			else if (cleared_by_nop) fail_ff <= 1'b0;
			if (runs && (low_supply_det || stat.low_supply)) lowv_ff <= 1'b1;
			else if (cleared_by_nop) lowv_ff <= 1'b0;
			if (runs && (hot_det || stat.hot)) hot_ff <= 1'b1;
			else if (cleared_by_nop) hot_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Second control register.
	always_ff @(posedge clk) begin
		if (rst) begin
			tag_ff <= 4'h0;
			sleep_ff <= `RST_SLEEP;
			wait_ff <= `RST_WAIT;
			cread_ff <= 1'b0;
			vread_ff <= 1'b0;
			strength_ff <= 2'h0;
		end else if (wr_ctl2) begin
			tag_ff <= req.wdata[`POS_RETRY_TAG+:4];
			if (unlock_ok) begin
				sleep_ff <= req.wdata[`POS_SLEEP];
				wait_ff <= req.wdata[`POS_WAIT+:5];
				cread_ff <= req.wdata[`POS_CREAD];
			end
			if (unlock_ok && !launch_ff) vread_ff <= req.wdata[`POS_VREAD];
			if (!launch_ff) strength_ff <= req.wdata[`POS_STRENGTH+:2];
		end
	end

	// The strap is caught by a clocked load after reset, never by the reset itself.
	always_ff @(posedge clk) begin
		if (rst) begin
			temp_loaded_ff <= 1'b0;
			temp_ff <= 1'b0;
		end else if (!temp_loaded_ff) begin
			temp_loaded_ff <= 1'b1;
			temp_ff <= temp_cfg;
		end else if (wr_ctl2 && unlock_ok && !launch_ff) begin
			temp_ff <= req.wdata[`POS_TEMP];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			power_down_in_sleep <= `RST_SLEEP;
			wait_count <= `RST_WAIT;
			low_latency_reads <= 1'b0;
		end else begin
			power_down_in_sleep <= sleep_ff;
			wait_count <= wait_ff;
			low_latency_reads <= temp_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare read of ones, effective only in verify mode.
	always_ff @(posedge clk) begin
		if (rst) begin
			read_word <= 32'h0000_0000;
		end else if (cread_word_valid) begin
			if (cread_ff && vread_ff) begin
				if (&flash_word)
					read_word <= (cread_word == '0) ? `CREAD_LOW_ONES : `CREAD_ONES;
				else
					read_word <= 32'h0000_0000;
			end else begin
				read_word <= flash_word[32*cread_word+:32];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads: data in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (req.rd && req.addr == `OFF_CONTROL)
				rdata <= {16'h0000, launch_ff, permit_ff, fail_ff, lowv_ff, 3'h0, hot_ff,
					4'h0, op_ff};
			else if (req.rd && req.addr == `OFF_CONTROL_SECOND)
				rdata <= {tag_ff, 3'h0, sleep_ff, 3'h0, wait_ff, 1'b0, temp_ff, cread_ff,
					vread_ff, 2'h0, strength_ff, 8'h00};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// A launch walks idle, check, then run and finish or finish alone, then back to idle.
	sequence s_launch_taken;
		launch_req ##1 ((state_ff == st_check) && launch_ff);
	endsequence

	sequence s_op_ends;
		(runs && stat.done) ##1 ((state_ff == st_finish) && launch_ff)
			##1 ((state_ff == st_idle) && !launch_ff);
	endsequence

	sequence s_nop_ends;
		cleared_by_nop ##1 (state_ff == st_check) ##1 (state_ff == st_finish)
			##1 !launch_ff;
	endsequence

	a_launch_clears: assert property (
		@(posedge clk) disable iff (rst || por)
		(state_ff == st_finish) |=> !launch_ff
	) else $error("launch not cleared");

	a_launch_gated: assert property (
		@(posedge clk) disable iff (rst || por)
		$rose(launch_ff) |-> $past(permit_ff) && $past(temp_ff) && $past(unlock_ok)
	) else $error("launch set without permission");

	a_op_locked: assert property (
		@(posedge clk) disable iff (rst || por)
		$past(permit_ff) |-> $stable(op_ff)
	) else $error("op changed with permit");

	a_nop_clears: assert property (
		@(posedge clk) disable iff (rst || por)
		cleared_by_nop && !runs |=> !fail_ff && !lowv_ff && !hot_ff
	) else $error("flags not cleared");

	a_lowv_only_run: assert property (
		@(posedge clk) disable iff (rst || por)
		$rose(lowv_ff) |-> $past(runs)
	) else $error("low supply outside op");

	a_hot_only_run: assert property (
		@(posedge clk) disable iff (rst || por)
		$rose(hot_ff) |-> $past(runs)
	) else $error("hot outside op");

	a_temp_locked: assert property (
		@(posedge clk) disable iff (rst || !temp_loaded_ff)
		$changed(temp_ff) && $past(temp_loaded_ff) |-> $past(unlock_ok) && !$past(launch_ff)
	) else $error("temp changed illegally");

	a_wait_locked: assert property (
		@(posedge clk) disable iff (rst)
		$changed(wait_ff) |-> $past(unlock_ok)
	) else $error("wait changed locked");

	// The decision is taken in the check cycle, one edge before the start pulse shows.
	a_protect_start: assert property (
		@(posedge clk) disable iff (rst || por)
		cmd.start |-> $past((op_ff > `OP_PAGE) ? !region_protected : !target_protected)
	) else $error("protected target started");

	a_launch_walk: assert property (
		@(posedge clk) disable iff (rst || por)
		launch_req |-> s_launch_taken
	) else $error("launch not taken");

	a_op_walk: assert property (
		@(posedge clk) disable iff (rst || por)
		runs && stat.done |-> s_op_ends
	) else $error("operation did not end cleanly");

	a_nop_walk: assert property (
		@(posedge clk) disable iff (rst || por)
		cleared_by_nop |-> s_nop_ends
	) else $error("no-operation launch did not end");

	a_start_pulse: assert property (
		@(posedge clk) disable iff (rst || por)
		cmd.start |=> !cmd.start
	) else $error("start longer than one cycle");

	a_start_runs: assert property (
		@(posedge clk) disable iff (rst || por)
		cmd.start |-> runs && launch_ff
	) else $error("start outside a launched run");

	a_refused_fail: assert property (
		@(posedge clk) disable iff (rst || por)
		(state_ff == st_check) && (nxt_state == st_finish) && (op_ff != `OP_NONE) |=> fail_ff
	) else $error("refused operation left fail clear");

	a_fail_only_op: assert property (
		@(posedge clk) disable iff (rst || por)
		$rose(fail_ff) |-> $past(runs || (state_ff == st_check))
	) else $error("fail set outside an operation");

	a_temp_blocks: assert property (
		@(posedge clk) disable iff (rst || por)
		!temp_ff |=> !$rose(launch_ff)
	) else $error("launch set at high temperature grade");

	a_strength_locked: assert property (
		@(posedge clk) disable iff (rst || por)
		launch_ff |=> $stable(strength_ff)
	) else $error("strength changed while busy");

	a_sleep_locked: assert property (
		@(posedge clk) disable iff (rst)
		$changed(sleep_ff) && !$past(rst) |-> $past(unlock_ok)
	) else $error("sleep changed while locked");

	a_cread_locked: assert property (
		@(posedge clk) disable iff (rst)
		$changed(cread_ff) && !$past(rst) |-> $past(unlock_ok)
	) else $error("compare read changed while locked");

	a_read_zero: assert property (
		@(posedge clk) disable iff (rst)
		cread_word_valid && cread_ff && vread_ff && !(&flash_word)
			|=> (read_word == 32'h0000_0000)
	) else $error("compare read of a zero bit not zero");

	a_read_ones: assert property (
		@(posedge clk) disable iff (rst)
		cread_word_valid && cread_ff && vread_ff && (&flash_word) && (cread_word != '0)
			|=> (read_word == `CREAD_ONES)
	) else $error("compare read of ones wrong");
endmodule : flash_program_erase_control

/* File: flash_array_model.sv */
/* Flash array stand-in: answers each start pulse with a done pulse.
   Assumes the bench sets the delay, the fail answer and the sensor levels. */
`timescale 1ns/1ps
module flash_array_model (
	input wire logic clk,
	input wire logic [3:0] delay,
	input wire logic fail_inj,
	input wire logic low_in,
	input wire logic hot_in,
	input wire flash_ctl_pkg::flash_cmd_type cmd,
	output flash_ctl_pkg::flash_stat_type stat
);
	import flash_ctl_pkg::*;
	logic [3:0] cnt_ff = 4'h0;
	logic busy_ff = 1'h0;
	logic junk_ff = 1'h0;
	always @(posedge clk) begin
		junk_ff <= !junk_ff;
		if (cmd.start) begin
			busy_ff <= 1'h1;
			cnt_ff <= delay;
		end else if (busy_ff && cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
		else busy_ff <= 1'h0;
	end
	// The fail answer only means something beside done, so it toggles elsewhere.
	assign stat.done = busy_ff && cnt_ff == 4'h0;
	assign stat.fail = stat.done ? fail_inj : junk_ff;
	assign stat.low_supply = low_in;
	assign stat.hot = hot_in;
endmodule : flash_array_model

/* File: flash_program_erase_control_test.sv */
/* Self-checking bench for the flash program/erase controller.
   Assumes the design, its package and the flash stand-in are compiled first. */
`timescale 1ns/1ps
`include "flash_ctl_cfg.svh"
module flash_program_erase_control_test;
	import flash_ctl_pkg::*;
	logic clk = 1'h0, rst = 1'h1, por = 1'h1, un = 1'h1, tp = 1'h0, rp = 1'h0;
	logic lo = 1'h0, ho = 1'h0, fi = 1'h0, cv = 1'h0, pd, ll;
	logic [1:0] ecc = 2'h1;
	logic [2:0] ci = 3'h0, fl = 3'h0;
	logic [3:0] dly = 4'h2;
	logic [6:0] last_cmd;
	logic [4:0] wc;
	logic [31:0] rdata, rw, v, d, sec;
	logic [255:0] fw = '1;
	reg_req_type req = '0;
	flash_stat_type stat;
	flash_cmd_type cmd;
	int bad_count = 0, compares = 0, starts = 0, seed = 63;
	initial forever #2 clk = !clk;
	flash_program_erase_control #(.WORDS(8)) flash_program_erase_control_inst (.clk(clk),
		.rst(rst), .por(por), .temp_cfg(1'h1), .req(req), .rdata(rdata), .unlock_ok(un),
		.target_protected(tp), .region_protected(rp), .ecc_setting(ecc), .low_supply_det(lo),
		.hot_det(ho), .stat(stat), .cmd(cmd), .flash_word(fw), .cread_word_valid(cv),
		.cread_word(ci), .read_word(rw), .power_down_in_sleep(pd), .wait_count(wc),
		.low_latency_reads(ll));
	flash_array_model flash_array_model_inst (.clk(clk), .delay(dly), .fail_inj(fi),
		.low_in(lo), .hot_in(ho), .cmd(cmd), .stat(stat));
	always @(posedge clk) if (cmd.start === 1'h1) begin
		starts++;
		last_cmd = {cmd.op, cmd.strength, cmd.verify};
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		req <= '{a, x, 1'h1, 1'h0};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		req <= '{a, 32'h0, 1'h0, 1'h1};
		@(posedge clk);
		req <= '0;
		#1 x = rdata;
		@(posedge clk);
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		chk("register", e, v);
	endtask : rchk
	task automatic cr(input logic [2:0] i, input logic [31:0] e);
		cv <= 1'h1;
		ci <= i;
		@(posedge clk);
		cv <= 1'h0;
		#1 chk("read word", e, rw);
		@(posedge clk);
	endtask : cr
	function automatic logic [31:0] ctl(input logic p, input logic [3:0] op);
		return {16'h0, 1'h0, p, fl[2:1], 3'h0, fl[0], 4'h0, op};
	endfunction : ctl
	// Protection and ECC refusals are judged from the levels held through the launch.
	task automatic launch(input logic [3:0] op, input logic go);
		logic bad_op, s;
		int n;
		bad_op = op > 4'h7 || (op == 4'h1 && ecc == 2'h0);
		bad_op = bad_op || (op inside {[1:4]} && tp) || (op inside {[5:7]} && rp);
		s = go && op != 4'h0 && !bad_op;
		starts = 0;
		wr(`OFF_CONTROL, {28'h0, op});
		wr(`OFF_CONTROL, {28'h0, op});
		wr(`OFF_CONTROL, {16'h0, 4'h4, 8'h0, op});
		wr(`OFF_CONTROL, {16'h0, 4'hc, 8'h0, op});
		rd(`OFF_CONTROL, v);
		for (n = 0; v[15] && n < 40; n++) rd(`OFF_CONTROL, v);
		if (go && op == 4'h0) fl = 3'h0;
		else if (go) fl = fl | {bad_op || (s && fi), s && lo, s && ho};
		chk("control", ctl(1'h1, op), v);
		chk("starts", 32'(s), starts);
		if (s) chk("cmd", {op, sec[9:8], sec[12]}, last_cmd);
	endtask : launch
	task automatic test_done;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
		repeat (2) @(posedge clk);
		sec = 32'h011f_4000;
		wr(8'h04, '1);
		rchk(8'h04, 32'h0);
		rchk(`OFF_CONTROL, 32'h0);
		rchk(`OFF_CONTROL_SECOND, sec);
		chk("copies", 7'h7f, {pd, wc, ll});
		wr(`OFF_CONTROL, 32'h0000_4002);
		wr(`OFF_CONTROL, 32'h0000_4006);
		rchk(`OFF_CONTROL, ctl(1'h1, 4'h2));
		wr(`OFF_CONTROL, 32'h0000_0006);
		starts = 0;
		wr(`OFF_CONTROL, 32'h0000_8002);
		rchk(`OFF_CONTROL, ctl(1'h0, 4'h2));
		chk("starts", 32'h0, starts);
		for (int i = 0; i < 24; i++) begin
			{tp, rp, fi, lo, ho, ecc, dly} <= 11'($random(seed));
			sec = 32'h011f_4000 | (32'($random(seed)) & 32'h0000_1300);
			@(posedge clk);
			wr(`OFF_CONTROL_SECOND, sec);
			launch(i < 8 ? 4'(i) : 4'($random(seed)), 1'h1);
		end
		un <= 1'h0;
		@(posedge clk);
		launch(4'h3, 1'h0);
		un <= 1'h1;
		wr(`OFF_CONTROL_SECOND, 32'h011f_0000);
		sec = 32'h011f_0000;
		launch(4'h2, 1'h0);
		for (int i = 0; i < 8; i++) begin
			un <= 1'($random(seed));
			d = $random(seed);
			@(posedge clk);
			wr(`OFF_CONTROL_SECOND, d);
			sec = (sec & ~(un ? 32'hf11f_7300 : 32'hf000_0300)) | (d & (un ? 32'hf11f_7300 : 32'hf000_0300));
			rchk(`OFF_CONTROL_SECOND, sec);
			chk("copies", {sec[24], sec[20:16], sec[14]}, {pd, wc, ll});
		end
		un <= 1'h1;
		wr(`OFF_CONTROL_SECOND, 32'h011f_7000);
		for (int i = 0; i < 8; i++) cr(3'(i), i == 0 ? 32'h1 : 32'h0001_0000);
		fw[8'($random(seed))] <= 1'h0;
		cr(3'h5, 32'h0);
		wr(`OFF_CONTROL_SECOND, 32'h011f_6000);
		cr(3'h2, fw[95:64]);
		wr(`OFF_CONTROL, 32'h0);
		wr(`OFF_CONTROL, 32'h0000_4005);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		rchk(`OFF_CONTROL, ctl(1'h1, 4'h5));
		rchk(`OFF_CONTROL_SECOND, 32'h011f_4000);
		{rst, por} <= 2'h3;
		repeat (2) @(posedge clk);
		{rst, por} <= 2'h0;
		repeat (2) @(posedge clk);
		rchk(`OFF_CONTROL, 32'h0);
		test_done;
	end
endmodule : flash_program_erase_control_test
